// ### rtl/obd_regs.vh
`ifndef OBD_REGS_VH
`define OBD_REGS_VH
// ----------------------------------------
// Register offsets (APB byte addresses)
// ----------------------------------------
`define OBD_CTRL_OFF 12'h000
`define OBD_STAT_OFF 12'h004
`define OBD_DECODE_OFF 12'h008
`define OBD_DATA_OFF 12'h00c
`define OBD_ADDR_OFF 12'h010
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OBD_BIT_WDG 5
`define OBD_BIT_NESTED_IRQ_SELECT 4
`define OBD_BIT_SDD 3
`define OBD_BIT_USBDIV 1
`define OBD_BIT_RDP 0
`define OBD_CTRL_PROG 0
`define OBD_CTRL_LOAD 1
`define OBD_CTRL_RDREQ 2
`define OBD_CTRL_WRREQ 3
// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define OBD_ERASED 8'hff
`define OBD_MEM_ERASED 8'hff
`define OBD_MEM_AW 8
`define OBD_MEM_DEPTH 256
`endif

// ### rtl/obd_option_byte_decoder.v
// Notes on behaviour
// RULE1: An erased option byte reads all ones so every option defaults to one.
// RULE2: The option byte has no processor address and only the programming tool in programming mode reaches it.
// RULE3: Bit 5 low starts the watchdog from reset in hardware, high leaves it to software.
// RULE4: Bit 4 low disables nested interrupts, high enables them.
// RULE5: Bit 3 low enables the supply-drop detector, high disables it.
// RULE6: The programmer must disable the supply-drop detector on low-voltage parts.
// RULE7: Bit 1 low passes a 6 MHz oscillator to USB, high divides a 12 MHz oscillator by two.
// RULE8: The programmer must pick the undivided 6 MHz setting on low-voltage parts.
// RULE9: Bit 0 low enables read-out protection, blocking external memory read and write.
// RULE10: Turning protection off erases the protected memory fully before reprogramming is allowed.
// RULE11: Factory-coded parts use a fixed option byte that cannot change.
// RULE12: Bits 7, 6 and 2 are reserved and ignored by the decoder.
`timescale 1ns/100ps
`include "obd_regs.vh"
module obd_option_byte_decoder #(
  parameter FACTORY_CODED = 0,
  parameter [7:0] FACTORY_BYTE = 8'hff
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire prog_mode,
  input wire [7:0] tool_option_byte,
  input wire tool_option_write,
  output wire [7:0] tool_option_read,
  output wire watchdog_start_type_select,
  output wire nested_irq_select,
  output wire supply_drop_detector_select,
  output wire usb_clock_divider_select,
  output wire readout_protect_select,
  output wire watchdog_hw_enable,
  output wire nested_irq_enable,
  output wire supply_drop_detector_enable,
  output wire usb_clock_divide_by_two,
  output wire readout_protect_active,
  output wire erase_busy
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_ERASE = 3'b010;
localparam [2:0] ST_DONE = 3'b100;

// ----------------------------------------
// Storage
// ----------------------------------------
reg [7:0] option_reg;
reg [7:0] option_next;
reg [7:0] mem_reg [0:`OBD_MEM_DEPTH-1];
reg [2:0] state_reg;
reg [`OBD_MEM_AW-1:0] erase_addr_reg;
reg [`OBD_MEM_AW-1:0] acc_addr_reg;
reg [7:0] acc_data_reg;
reg prog_en_reg;
reg block_reg;
reg [7:0] rd_data_reg;
reg [7:0] pending_reg;
reg pending_valid_reg;
integer i;

// ----------------------------------------
// Internal control
// ----------------------------------------
wire [7:0] eff_byte = (FACTORY_CODED != 0) ? FACTORY_BYTE : option_reg; // RULE11
wire bus_access = psel && penable;
wire wr_acc = bus_access && pwrite;
wire rd_acc = bus_access && !pwrite;
wire hit_ctrl;
wire hit_stat;
wire hit_decode;
wire hit_data;
wire hit_addr;
wire addr_ok;
wire erasing = state_reg == ST_ERASE;
wire mem_open = prog_en_reg && !readout_protect_active && !erasing;
wire mem_blocked = !mem_open;
wire [7:0] mem_rd_byte = mem_reg[acc_addr_reg];

// ----------------------------------------
// Erase control
// ----------------------------------------
wire erase_start = (option_next != option_reg) && readout_protect_active && option_next[`OBD_BIT_RDP];
wire erase_last = &erase_addr_reg;

// ----------------------------------------
// Bus response
// ----------------------------------------
assign pready = 1'b1;
assign pslverr = bus_access && !addr_ok;

// ----------------------------------------
// Decode
// ----------------------------------------
function bit_of;
  input [7:0] b;
  input integer pos;
  begin
    bit_of = b[pos];
  end
endfunction

assign watchdog_start_type_select = bit_of(eff_byte, `OBD_BIT_WDG);
assign nested_irq_select = bit_of(eff_byte, `OBD_BIT_NESTED_IRQ_SELECT);
assign supply_drop_detector_select = bit_of(eff_byte, `OBD_BIT_SDD);
assign usb_clock_divider_select = bit_of(eff_byte, `OBD_BIT_USBDIV);
assign readout_protect_select = bit_of(eff_byte, `OBD_BIT_RDP);
assign watchdog_hw_enable = !watchdog_start_type_select; // RULE3
assign nested_irq_enable = nested_irq_select; // RULE4
assign supply_drop_detector_enable = !supply_drop_detector_select; // RULE5
assign usb_clock_divide_by_two = usb_clock_divider_select; // RULE7
assign readout_protect_active = !readout_protect_select; // RULE9
assign erase_busy = erasing;
// Reserved bits 7, 6 and 2 feed no decoded output, only tool_option_read
assign tool_option_read = prog_mode ? eff_byte : 8'h00; // RULE2 RULE12

// ----------------------------------------
// Address decode
// ----------------------------------------
function addr_hit;
  input [11:0] a;
  input [11:0] off;
  begin
    addr_hit = (a == off);
  end
endfunction

assign hit_ctrl = addr_hit(paddr, `OBD_CTRL_OFF);
assign hit_stat = addr_hit(paddr, `OBD_STAT_OFF);
assign hit_decode = addr_hit(paddr, `OBD_DECODE_OFF);
assign hit_data = addr_hit(paddr, `OBD_DATA_OFF);
assign hit_addr = addr_hit(paddr, `OBD_ADDR_OFF);
assign addr_ok = hit_ctrl || hit_stat || hit_decode || hit_data || hit_addr;

wire ctrl_wr = wr_acc && hit_ctrl;
wire stat_rd = rd_acc && hit_stat;
wire addr_wr = wr_acc && hit_addr;
wire data_wr = wr_acc && hit_data;
wire rd_req = ctrl_wr && pwdata[`OBD_CTRL_RDREQ];
wire wr_req = ctrl_wr && pwdata[`OBD_CTRL_WRREQ];

// ----------------------------------------
// Option byte, tool side only
// ----------------------------------------
always @* begin
  option_next = option_reg;
  if (prog_mode && tool_option_write && (FACTORY_CODED == 0)) begin // RULE2 RULE11
    option_next = tool_option_byte;
  end
end

// ----------------------------------------
// Erase sequencer
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    option_reg <= `OBD_ERASED; // RULE1
    state_reg <= ST_IDLE;
    erase_addr_reg <= {`OBD_MEM_AW{1'b0}};
    pending_reg <= `OBD_ERASED;
    pending_valid_reg <= 1'b0;
  end else begin
    case (state_reg)
      ST_IDLE: begin
        if (erase_start) begin
          pending_reg <= option_next; // RULE10
          pending_valid_reg <= 1'b1;
          erase_addr_reg <= {`OBD_MEM_AW{1'b0}};
          state_reg <= ST_ERASE;
        end else begin
          option_reg <= option_next;
        end
      end
      ST_ERASE: begin
        erase_addr_reg <= erase_addr_reg + {{(`OBD_MEM_AW-1){1'b0}}, 1'b1};
        if (erase_last) begin
          state_reg <= ST_DONE;
        end
      end
      ST_DONE: begin
        option_reg <= pending_reg; // RULE10
        pending_valid_reg <= 1'b0;
        state_reg <= ST_IDLE;
      end
      default: begin
        state_reg <= ST_IDLE;
      end
    endcase
  end
end

// ----------------------------------------
// Memory array
// ----------------------------------------
always @(posedge pclk) begin
  if (erasing) begin
    mem_reg[erase_addr_reg] <= `OBD_MEM_ERASED; // RULE10
  end else if (wr_req && mem_open) begin // RULE9
    mem_reg[acc_addr_reg] <= acc_data_reg;
  end
end

// ----------------------------------------
// Programming enable
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prog_en_reg <= 1'b0;
  end else if (ctrl_wr) begin
    prog_en_reg <= pwdata[`OBD_CTRL_PROG];
  end
end

// ----------------------------------------
// Memory index
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    acc_addr_reg <= {`OBD_MEM_AW{1'b0}};
  end else if (addr_wr) begin
    acc_addr_reg <= pwdata[`OBD_MEM_AW-1:0];
  end
end

// ----------------------------------------
// Memory write data
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    acc_data_reg <= 8'h00;
  end else if (data_wr) begin
    acc_data_reg <= pwdata[7:0];
  end
end

// ----------------------------------------
// Memory read data
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    rd_data_reg <= 8'h00;
  end else if (rd_req && mem_open) begin
    rd_data_reg <= mem_rd_byte;
  end else if (rd_req) begin
    rd_data_reg <= 8'h00; // RULE9
  end
end

// ----------------------------------------
// Blocked access flag, set wins
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    block_reg <= 1'b0;
  end else if ((rd_req || wr_req) && mem_blocked) begin
    block_reg <= 1'b1; // RULE9
  end else if (stat_rd) begin
    block_reg <= 1'b0;
  end
end

// ----------------------------------------
// Read data mux
// ----------------------------------------
always @* begin
  prdata = 32'h0000_0000;
  if (rd_acc) begin
    case (paddr)
      `OBD_CTRL_OFF: prdata = {31'h0000_0000, prog_en_reg};
      `OBD_STAT_OFF: prdata = {28'h000_0000, pending_valid_reg, block_reg, erasing, readout_protect_active};
      `OBD_DECODE_OFF: prdata = {27'h000_0000, watchdog_hw_enable, nested_irq_enable,
        supply_drop_detector_enable, usb_clock_divide_by_two, readout_protect_active};
      `OBD_DATA_OFF: prdata = {24'h00_0000, rd_data_reg};
      `OBD_ADDR_OFF: prdata = {24'h00_0000, acc_addr_reg};
      default: prdata = 32'h0000_0000;
    endcase
  end
end

// ----------------------------------------
// Memory fill at power-up
// ----------------------------------------
initial begin
  for (i = 0; i < `OBD_MEM_DEPTH; i = i + 1) begin
    mem_reg[i] = `OBD_MEM_ERASED;
  end
end

endmodule // obd_option_byte_decoder

// ### verif/obd_option_byte_decoder_asserts.sv
`timescale 1ns/100ps
module obd_option_byte_decoder_asserts (
  input wire pclk,
  input wire presetn,
  input wire prog_mode,
  input wire [7:0] tool_option_byte,
  input wire tool_option_write,
  input wire [7:0] tool_option_read,
  input wire watchdog_start_type_select,
  input wire nested_irq_select,
  input wire supply_drop_detector_select,
  input wire usb_clock_divider_select,
  input wire readout_protect_select,
  input wire watchdog_hw_enable,
  input wire nested_irq_enable,
  input wire supply_drop_detector_enable,
  input wire usb_clock_divide_by_two,
  input wire readout_protect_active,
  input wire erase_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [4:0] sel = {watchdog_start_type_select, nested_irq_select, supply_drop_detector_select,
    usb_clock_divider_select, readout_protect_select};
  property p_wdg; watchdog_hw_enable != watchdog_start_type_select; endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog decode wrong");
  property p_nested_irq_select; nested_irq_enable == nested_irq_select; endproperty
  a_nested_irq_select: assert property (p_nested_irq_select) else $error("nesting decode wrong");
  property p_sdd; supply_drop_detector_enable != supply_drop_detector_select; endproperty
  a_sdd: assert property (p_sdd) else $error("detector decode wrong");
  property p_usb; usb_clock_divide_by_two == usb_clock_divider_select; endproperty
  a_usb: assert property (p_usb) else $error("usb divider decode wrong");
  property p_rdp; readout_protect_active != readout_protect_select; endproperty
  a_rdp: assert property (p_rdp) else $error("protection decode wrong");
  property p_rst; $rose(presetn) |-> sel == 5'h1f; endproperty
  a_rst: assert property (p_rst) else $error("option byte not erased after reset");
  property p_hide; !prog_mode |-> tool_option_read == 8'h00; endproperty
  a_hide: assert property (p_hide) else $error("option byte visible outside programming");
  property p_upd;
    prog_mode && tool_option_write && !erase_busy && !(readout_protect_active && tool_option_byte[0])
      |=> sel == {$past(tool_option_byte[5:3]), $past(tool_option_byte[1:0])};
  endproperty
  a_upd: assert property (p_upd) else $error("option byte not taken");
  property p_erase;
    $rose(erase_busy) |-> (erase_busy && readout_protect_active)[*8] ##[1:300] !erase_busy;
  endproperty
  a_erase: assert property (p_erase) else $error("erase sequence wrong");
  c_write: cover property (prog_mode && tool_option_write);
  c_prot: cover property (readout_protect_active);
  c_erase: cover property ($fell(erase_busy));
endmodule // obd_option_byte_decoder_asserts
bind obd_option_byte_decoder obd_option_byte_decoder_asserts u_chk (.*);

// ### verif/obd_tool_model.sv
`timescale 1ns/100ps
module obd_tool_model (
  input wire pclk,
  input wire enter,
  input wire go,
  input wire low_volt,
  input wire [7:0] byte_in,
  output reg prog_mode,
  output reg [7:0] tool_option_byte,
  output reg tool_option_write
);
  initial begin
    prog_mode = 1'b0;
    tool_option_write = 1'b0;
    tool_option_byte = 8'h00;
  end
  always @(posedge pclk) begin
    prog_mode <= enter;
    tool_option_write <= go & enter;
    tool_option_byte <= !go ? ~tool_option_byte : low_volt ? (byte_in | 8'h08) & 8'hfd : byte_in;
  end
endmodule // obd_tool_model

// ### verif/obd_option_byte_decoder_tb.sv
`timescale 1ns/100ps
module obd_option_byte_decoder_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, enter = 0, go = 0, lv = 0, er;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [7:0] bi = 0, ma, md;
  wire [31:0] prdata;
  wire pready, pslverr, prog_mode, tool_option_write, erase_busy;
  wire [7:0] tool_option_byte, tool_option_read;
  wire [4:0] sel, en;
  integer fails = 0, checks_done = 0, seed = 34776, i, mb;
  always #10 pclk = ~pclk;
  obd_option_byte_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_mode(prog_mode),
    .tool_option_byte(tool_option_byte), .tool_option_write(tool_option_write), .tool_option_read(tool_option_read),
    .watchdog_start_type_select(sel[4]), .nested_irq_select(sel[3]), .supply_drop_detector_select(sel[2]),
    .usb_clock_divider_select(sel[1]), .readout_protect_select(sel[0]), .watchdog_hw_enable(en[4]),
    .nested_irq_enable(en[3]), .supply_drop_detector_enable(en[2]), .usb_clock_divide_by_two(en[1]),
    .readout_protect_active(en[0]), .erase_busy(erase_busy));
  obd_tool_model u_tool (.pclk(pclk), .enter(enter), .go(go), .low_volt(lv), .byte_in(bi), .prog_mode(prog_mode),
    .tool_option_byte(tool_option_byte), .tool_option_write(tool_option_write));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
    end
  endtask
  task tool(input [7:0] b);
    begin
      bi <= b; go <= 1;
      @(posedge pclk) go <= 0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task verify;
    reg [4:0] e;
    begin
      e = {~mb[5], mb[4], ~mb[3], mb[1], ~mb[0]};
      check(sel, {mb[5:3], mb[1:0]});
      check(en, e);
      apb(0, 12'h008, 0);
      check(rd, e);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #100000 fails = fails + 1;
    summarize;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk) mb = 8'hff;
    verify;
    apb(1, 12'h008, $random(seed));
    apb(0, 12'h0f0, 0);
    check(er, 1);
    check(rd, 0);
    check(pready, 1);
    verify;
    $display("reset and bus done");
    enter <= 1;
    @(posedge pclk);
    for (i = 0; i < 24; i = i + 1) begin
      mb = $random(seed) | 1;
      tool(mb[7:0]);
      verify;
      check(tool_option_read, mb[7:0]);
    end
    $display("decode done");
    enter <= 0;
    repeat (2) @(posedge pclk);
    tool(8'h00);
    check(tool_option_read, 0);
    verify;
    enter <= 1; lv <= 1;
    @(posedge pclk) mb = 8'hfd;
    tool(8'hf7);
    verify;
    ma = $random(seed);
    md = $random(seed);
    apb(1, 12'h000, 32'h0000_0001);
    apb(1, 12'h010, ma);
    apb(1, 12'h00c, md);
    apb(1, 12'h000, 32'h0000_0009);
    apb(1, 12'h000, 32'h0000_0005);
    apb(0, 12'h00c, 0);
    check(rd, md);
    lv <= 0; mb = 8'hfe;
    tool(8'hfe);
    verify;
    apb(1, 12'h000, 32'h0000_0005);
    apb(0, 12'h00c, 0);
    check(rd, 0);
    apb(0, 12'h004, 0);
    check(rd, 5);
    tool(8'hff);
    check({erase_busy, sel[0]}, 2'b10);
    i = 0;
    while (erase_busy === 1'b1 && i < 400) begin
      @(posedge pclk) i = i + 1;
    end
    check(i > 240 && i < 270, 1);
    repeat (2) @(posedge pclk) mb = 8'hff;
    verify;
    apb(1, 12'h000, 32'h0000_0005);
    apb(0, 12'h00c, 0);
    check(rd, 8'hff);
    $display("protection done");
    summarize;
  end
endmodule // obd_option_byte_decoder_tb
